// [prio_queue_fold.sv]
module prio_queue_fold
  import tag_prio_pkg::*;
(
  // Inputs
  input  wire logic [1:0] i_prio,
  input  wire logic [1:0] i_fold_sel,
  input  wire logic       i_two_queue,
  // Output
  output logic      [1:0] o_queue
);

  logic high;

  always_comb begin
    case (i_prio)
      2'h0:    high = 1'b0;
      2'h1:    high = i_fold_sel[0];
      2'h2:    high = i_fold_sel[1];
      default: high = 1'b1;
    endcase
    // Four-queue mode passes the priority through untouched
    if (i_two_queue) begin
      o_queue = {1'b0, high};
    end else begin
      o_queue = i_prio;
    end
  end

endmodule : prio_queue_fold

// [tag_prio_pkg.sv]
package tag_prio_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] TAG_MAP_UPPER_ADDR = 8'h81;
  localparam logic [7:0] FOLD_CTRL_ADDR     = 8'h82;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned PRIO_SEVEN_LSB = 6;
  localparam int unsigned PRIO_SIX_LSB   = 4;
  localparam int unsigned PRIO_FIVE_LSB  = 2;
  localparam int unsigned PRIO_FOUR_LSB  = 0;
  localparam int unsigned FOLD_SEL_LSB   = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] PRIO_SEVEN_RST    = 2'h3;
  localparam logic [1:0] PRIO_SIX_RST      = 2'h3;
  localparam logic [1:0] PRIO_FIVE_RST     = 2'h2;
  localparam logic [1:0] PRIO_FOUR_RST     = 2'h2;
  localparam logic [7:0] TAG_MAP_UPPER_RST = {PRIO_SEVEN_RST, PRIO_SIX_RST, PRIO_FIVE_RST, PRIO_FOUR_RST};
  localparam logic [7:0] FOLD_CTRL_RST     = 8'h00;

  // ****************************************
  // Tag values served by the upper map
  // ****************************************
  localparam logic [2:0] TAG_SEVEN = 3'h7;
  localparam logic [2:0] TAG_SIX   = 3'h6;
  localparam logic [2:0] TAG_FIVE  = 3'h5;
  localparam logic [2:0] TAG_FOUR  = 3'h4;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic       valid;
    logic       from_tos;
    logic [2:0] tag;
    logic [1:0] tos_prio;
    logic [1:0] lower_prio;
  } cls_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] prio;
    logic [1:0] queue;
  } cls_res_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } reg_rsp_t;

endpackage : tag_prio_pkg

// [tag_priority_queue_mapper.sv]
// Notes on behaviour
// - Tag 7 frames take a programmable 2-bit priority, reset value 3.
// - Tag 6 frames take their own programmable 2-bit priority, reset value 3.
// - Tag 5 frames take their own programmable 2-bit priority, reset value 2.
// - Tag 4 frames take their own programmable 2-bit priority, reset value 2.
// - Two-queue mode folds any 2-bit result into low or high by selection.
// - Result 0 always goes low, result 3 always high, in two-queue mode.
// - Result 1 goes high when selection bit 0 is set, else low.
// - Result 2 goes high when selection bit 1 is set, else low.
// - Selection 00: results 0, 1, 2 low, only 3 high.
// - Selection 11: result 0 low, results 1, 2, 3 high.
module tag_priority_queue_mapper
  import tag_prio_pkg::*;
(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_reset,
  input  wire logic              i_clk_en,
  // Configuration
  input  wire logic              i_two_queue,
  // Register port
  input  tag_prio_pkg::reg_req_t i_reg,
  output tag_prio_pkg::reg_rsp_t o_reg,
  // Classification
  input  tag_prio_pkg::cls_req_t i_cls,
  output tag_prio_pkg::cls_res_t o_cls
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] tag_map_upper;
    logic [7:0] fold_ctrl;
    reg_rsp_t   rsp;
    cls_res_t   res;
  } state_t;

  state_t     state_r;
  state_t     state_nxt;
  logic [1:0] mapped_prio;
  logic [1:0] folded_queue;
  logic [1:0] fold_sel;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [1:0] field2(input logic [7:0] word, input int unsigned lsb);
    field2 = word[lsb +: 2];
  endfunction : field2

  function automatic logic [7:0] read_word(input logic [7:0] addr, input logic [7:0] map_w,
                                           input logic [7:0] fold_w);
    if (addr == TAG_MAP_UPPER_ADDR) begin
      read_word = map_w;
    end else if (addr == FOLD_CTRL_ADDR) begin
      read_word = fold_w;
    end else begin
      // Unmapped offsets read as zero
      read_word = 8'h00;
    end
  endfunction : read_word

  // ****************************************
  // Priority lookup
  // ****************************************
  // Uses the stored map only, so a write landing on the same edge
  // as a request reaches the next request, never half of this one
  always_comb begin
    if (i_cls.from_tos) begin
      mapped_prio = i_cls.tos_prio;
    end else begin
      case (i_cls.tag)
        TAG_SEVEN: mapped_prio = field2(state_r.tag_map_upper, PRIO_SEVEN_LSB);
        TAG_SIX:   mapped_prio = field2(state_r.tag_map_upper, PRIO_SIX_LSB);
        TAG_FIVE:  mapped_prio = field2(state_r.tag_map_upper, PRIO_FIVE_LSB);
        TAG_FOUR:  mapped_prio = field2(state_r.tag_map_upper, PRIO_FOUR_LSB);
        // Tags 0 to 3 are mapped by the neighbouring register
        default:   mapped_prio = i_cls.lower_prio;
      endcase
    end
    fold_sel = field2(state_r.fold_ctrl, FOLD_SEL_LSB);
  end

  // ****************************************
  // Queue fold
  // ****************************************
  prio_queue_fold u_fold (
    .i_prio      (mapped_prio),
    .i_fold_sel  (fold_sel),
    .i_two_queue (i_two_queue),
    .o_queue     (folded_queue)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    // Register writes
    if (i_reg.wr) begin
      if (i_reg.addr == TAG_MAP_UPPER_ADDR) begin
        state_nxt.tag_map_upper = i_reg.wdata;
      end else if (i_reg.addr == FOLD_CTRL_ADDR) begin
        state_nxt.fold_ctrl = i_reg.wdata;
      end
    end
    // Read answer one cycle after the request, shows pre-write contents
    state_nxt.rsp.valid = i_reg.rd;
    if (i_reg.rd) begin
      state_nxt.rsp.data = read_word(i_reg.addr, state_r.tag_map_upper, state_r.fold_ctrl);
    end
    // Result is latched once; later writes never revisit it
    state_nxt.res.valid = i_cls.valid;
    if (i_cls.valid) begin
      state_nxt.res.prio  = mapped_prio;
      state_nxt.res.queue = folded_queue;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r.tag_map_upper <= TAG_MAP_UPPER_RST;
      state_r.fold_ctrl     <= FOLD_CTRL_RST;
      state_r.rsp           <= '0;
      state_r.res           <= '0;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_reg = state_r.rsp;
  assign o_cls = state_r.res;

endmodule : tag_priority_queue_mapper

// [tag_priority_queue_mapper_assertions.sv]
module tag_priority_queue_mapper_assertions
  import tag_prio_pkg::*;
(
  // Watched ports
  input wire logic              i_sys_clk,
  input wire logic              i_reset,
  input wire logic              i_clk_en,
  input wire logic              i_two_queue,
  input tag_prio_pkg::reg_req_t i_reg,
  input tag_prio_pkg::reg_rsp_t o_reg,
  input tag_prio_pkg::cls_req_t i_cls,
  input tag_prio_pkg::cls_res_t o_cls
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence take_cls; i_clk_en && i_cls.valid; endsequence
  sequence wr_fold; i_clk_en && i_reg.wr && i_reg.addr == FOLD_CTRL_ADDR; endsequence
  sequence wr_map; i_clk_en && i_reg.wr && i_reg.addr == TAG_MAP_UPPER_ADDR; endsequence
  read_answer_a: assert property (i_clk_en && i_reg.rd |=> o_reg.valid) else $error("no read answer");
  tos_result_a: assert property (take_cls ##0 i_cls.from_tos |=> o_cls.prio == $past(i_cls.tos_prio))
    else $error("tos result lost");
  fold_zero_a: assert property (take_cls ##0 i_two_queue |=> o_cls.prio != 2'h0 || o_cls.queue == 2'h0)
    else $error("result 0 not low");
  fold_three_a: assert property (take_cls ##0 i_two_queue |=> o_cls.prio != 2'h3 || o_cls.queue == 2'h1)
    else $error("result 3 not high");
  four_queue_a: assert property (take_cls ##0 !i_two_queue |=> o_cls.valid && o_cls.queue == o_cls.prio)
    else $error("four queue mismatch");
  idle_result_a: assert property (i_clk_en && !i_cls.valid |=> !o_cls.valid) else $error("spurious result");
  frozen_hold_a: assert property (!i_clk_en |=> $stable(o_cls) && $stable(o_reg))
    else $error("outputs moved while frozen");
  fold_one_a: assert property (wr_fold ##1 take_cls ##0 (i_two_queue && i_cls.from_tos && i_cls.tos_prio == 2'h1)
    |=> o_cls.queue == {1'b0, $past(i_reg.wdata[6], 2)}) else $error("result 1 fold wrong");
  fold_two_a: assert property (wr_fold ##1 take_cls ##0 (i_two_queue && i_cls.from_tos && i_cls.tos_prio == 2'h2)
    |=> o_cls.queue == {1'b0, $past(i_reg.wdata[7], 2)}) else $error("result 2 fold wrong");
  tag_seven_a: assert property (wr_map ##1 take_cls ##0 (!i_cls.from_tos && i_cls.tag == TAG_SEVEN)
    |=> o_cls.prio == $past(i_reg.wdata[7:6], 2)) else $error("tag 7 map wrong");
endmodule : tag_priority_queue_mapper_assertions

bind tag_priority_queue_mapper tag_priority_queue_mapper_assertions chk_u (.i_sys_clk(i_sys_clk),
  .i_reset(i_reset), .i_clk_en(i_clk_en), .i_two_queue(i_two_queue), .i_reg(i_reg), .o_reg(o_reg),
  .i_cls(i_cls), .o_cls(o_cls));

// [tb_tag_priority_queue_mapper.sv]
module tb_tag_priority_queue_mapper;
  timeunit 1ns;
  timeprecision 1ps;
  import tag_prio_pkg::*;
  // ****************************************
  // Bench
  // ****************************************
  logic     sys_clk   = 1'b0;
  logic     reset     = 1'b1;
  logic     two_queue = 1'b0;
  logic     clk_en    = 1'b1;
  reg_req_t reg_req   = '0;
  cls_req_t cls_req   = '0;
  reg_rsp_t reg_rsp;
  cls_res_t cls_res;
  int       err_total   = 0;
  int       check_count = 0;
  always #2 sys_clk = ~sys_clk;
  tag_priority_queue_mapper dut_u (.i_sys_clk(sys_clk), .i_reset(reset), .i_clk_en(clk_en),
    .i_two_queue(two_queue), .i_reg(reg_req), .o_reg(reg_rsp), .i_cls(cls_req), .o_cls(cls_res));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk);
    reg_req.rd = 1'b0;
    chk({reg_rsp.valid, reg_rsp.data}, {1'b1, e});
  endtask : rd
  task automatic cls(input logic ft, input logic [2:0] t, input logic [1:0] tos, input logic [1:0] p,
                     input logic [1:0] q);
    @(negedge sys_clk);
    cls_req = '{1'b1, ft, t, tos, 2'h1};
    @(negedge sys_clk);
    cls_req.valid = 1'b0;
    chk({cls_res.valid, 4'h0, cls_res.prio, cls_res.queue}, {1'b1, 4'h0, p, q});
  endtask : cls
  // Write on one edge, request on the very next, so the new field is used at once
  task automatic wr_cls(input logic [7:0] a, input logic [7:0] d, input logic ft, input logic [2:0] t,
                        input logic [1:0] tos, input logic [1:0] p, input logic [1:0] q);
    @(negedge sys_clk);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
    cls_req    = '{1'b1, ft, t, tos, 2'h1};
    @(negedge sys_clk);
    cls_req.valid = 1'b0;
    chk({cls_res.valid, 4'h0, cls_res.prio, cls_res.queue}, {1'b1, 4'h0, p, q});
  endtask : wr_cls
  task automatic t_map();
    rd(TAG_MAP_UPPER_ADDR, 8'hfa);
    rd(8'h80, 8'h00);
    cls(1'b0, 3'h6, 2'h0, 2'h3, 2'h3);
    cls(1'b0, 3'h2, 2'h0, 2'h1, 2'h1);
    wr_cls(TAG_MAP_UPPER_ADDR, 8'h1b, 1'b0, TAG_SEVEN, 2'h0, 2'h0, 2'h0);
    for (int i = 0; i < 4; i++) cls(1'b0, 3'(7 - i), 2'h0, 2'(i), 2'(i));
  endtask : t_map
  task automatic t_fold();
    logic hi;
    two_queue = 1'b1;
    rd(FOLD_CTRL_ADDR, 8'h00);
    for (int s = 0; s < 4; s++) for (int p = 0; p < 4; p++) begin
      hi = (p == 3) || (p == 1 && s[0]) || (p == 2 && s[1]);
      wr_cls(FOLD_CTRL_ADDR, {2'(s), 6'h00}, 1'b1, 3'h0, 2'(p), 2'(p), {1'b0, hi});
    end
  endtask : t_fold
  task automatic t_order();
    wr(FOLD_CTRL_ADDR, 8'h00);
    @(negedge sys_clk);
    reg_req = '{1'b1, 1'b0, FOLD_CTRL_ADDR, 8'hc0};
    cls_req = '{1'b1, 1'b1, 3'h0, 2'h1, 2'h0};
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
    cls_req.valid = 1'b0;
    chk({cls_res.valid, 6'h0, cls_res.queue}, 9'h100);
    cls(1'b1, 3'h0, 2'h1, 2'h1, 2'h1);
  endtask : t_order
  // Write and request while frozen must both be ignored
  task automatic t_freeze();
    cls(1'b1, 3'h0, 2'h2, 2'h2, 2'h1);
    @(negedge sys_clk);
    clk_en  = 1'b0;
    reg_req = '{1'b1, 1'b0, TAG_MAP_UPPER_ADDR, 8'h00};
    cls_req = '{1'b1, 1'b0, TAG_SEVEN, 2'h0, 2'h0};
    @(negedge sys_clk);
    clk_en        = 1'b1;
    reg_req.wr    = 1'b0;
    cls_req.valid = 1'b0;
    chk({cls_res.valid, 4'h0, cls_res.prio, cls_res.queue}, 9'h009);
    rd(TAG_MAP_UPPER_ADDR, 8'h1b);
  endtask : t_freeze
  // Mid-run reset brings both fields back to their defaults
  task automatic t_reset();
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    chk({cls_res.valid, 4'h0, cls_res.prio, cls_res.queue}, 9'h000);
    rd(TAG_MAP_UPPER_ADDR, 8'hfa);
    rd(FOLD_CTRL_ADDR, 8'h00);
  endtask : t_reset
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #4000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    t_map();
    t_fold();
    t_order();
    t_freeze();
    t_reset();
    end_of_test();
  end
endmodule : tb_tag_priority_queue_mapper
